// ===== pcis_defines.svh
`ifndef PCIS_DEFINES_SVH
`define PCIS_DEFINES_SVH

// Register indexes on the management interface
`define PCIS_IDX_XOVER      5'h1B
`define PCIS_IDX_IRQ_FLAGS  5'h1D
`define PCIS_IDX_IRQ_MASK   5'h1E
`define PCIS_IDX_NEG_STATUS 5'h1F

// Crossover / PLL / polarity register bit positions
`define PCIS_XO_OVERRIDE_BIT 15
`define PCIS_XO_AUTO_BIT     14
`define PCIS_XO_MANUAL_BIT   13
`define PCIS_XO_PLL_BIT      10
`define PCIS_XO_POL_BIT      4

// Negotiation status register fields
`define PCIS_NS_DONE_BIT     12
`define PCIS_NS_RSV_HI       11
`define PCIS_NS_RSV_LO       5
`define PCIS_NS_SPD_HI       4
`define PCIS_NS_SPD_LO       2
`define PCIS_NS_RSV_RST      7'h02

// Interrupt flag positions
`define PCIS_IRQ_ENERGY      7
`define PCIS_IRQ_NEG_DONE    6
`define PCIS_IRQ_REM_FAULT   5
`define PCIS_IRQ_LINK_DOWN   4
`define PCIS_IRQ_PARTNER_ACK 3
`define PCIS_IRQ_PAR_FAULT   2
`define PCIS_IRQ_PAGE_RX     1
`define PCIS_MASK_RST        8'h00

// Management frame layout
`define PCIS_PHY_ADDR_DEF    5'h01
`define PCIS_OP_READ         2'h2
`define PCIS_OP_WRITE        2'h1
`define PCIS_HDR_BITS        5'h0C
`define PCIS_TA_BITS         5'h02
`define PCIS_DATA_BITS       5'h10

// Energy timeout: time in ms and core clock in kHz
`define PCIS_ENERGY_MS       256
`define PCIS_CLK_KHZ         200000

`endif

// ===== pcis_pkg.sv
package pcis_pkg;

    // Frame engine phases
    typedef enum logic [2:0] {
        PCIS_PREAMBLE = 3'b000,
        PCIS_START    = 3'b001,
        PCIS_HEADER   = 3'b010,
        PCIS_TURN     = 3'b011,
        PCIS_RDATA    = 3'b100,
        PCIS_WDATA    = 3'b101
    } pcis_phase_t;

    // Line and negotiation status from the PHY core
    typedef struct packed {
        logic       link_up;
        logic       line_energy;
        logic       an_done;
        logic       remote_fault;
        logic       partner_ack;
        logic       parallel_fault;
        logic       page_rx;
        logic       rx_polarity_reversed;
        logic [2:0] resolved_speed_duplex;
    } pcis_line_t;

    // Crossover and PLL controls to the PHY core
    typedef struct packed {
        logic auto_en;
        logic manual_swap;
        logic rx_pll_ref_lock;
    } pcis_xover_t;

    // Whole state of the register bank
    typedef struct packed {
        logic        mdc_prev;
        pcis_phase_t phase;
        logic        pre_seen;
        logic [4:0]  cnt;
        logic [15:0] shift;
        logic        is_read;
        logic        hit;
        logic [4:0]  idx;
        logic        mdio_out;
        logic        mdio_oe;
        logic        xo_override;
        logic        xo_auto;
        logic        xo_manual;
        logic        pll_ref;
        logic [6:0]  ns_rsv;
        logic [7:0]  mask;
        logic [7:1]  flags;
        logic        energy_present;
        logic [31:0] energy_cnt;
        logic        an_prev;
        logic        irq;
        pcis_xover_t xover;
    } pcis_state_t;

endpackage

// ===== pcis_sync.sv
`timescale 1ns/1ps

module pcis_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // Two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ===== pcis_regs.sv
`timescale 1ns/1ps
`include "pcis_defines.svh"

// Functional notes
// - Override clear: strap pin picks auto crossover; set: register bits 14/13 decide.
// - With override, bit 14 at 1 enables auto crossover, 0 selects manual.
// - Manual mode: bit 13 at 0 keeps pairs normal, 1 swaps their directions.
// - Bit 10 set holds the 10 Mb/s receive PLL on reference clock.
// - Bit 4 reports receive polarity: 0 normal, 1 reversed; read only.
// - Bits 3:0 of crossover register are read only; writes change nothing.
// - Flag register bits 7..1 name the interrupt causes; bit 0, 15:8 read 0.
// - Link-down flag leaves reset showing the current link state.
// - Mask bits 7:0 reset to 0; 1 in bits 7:1 enables a source, bit 0 gates nothing; upper bits read 0.
// - Status bit 12 reads 1 once negotiation is done, else 0; it follows an_done directly, with no reset.
// - Status bits 4:2 give resolved speed and duplex code.
// - Speed code comes from the negotiation outcome, not a fixed reset.
// - Status bits 11:5 reset to 0000010 and are stored as written.
// - Device answers frames addressed to its PHY address, default 00001.
// - Energy indication drops after 256 ms without energy; edges raise a flag.
module pcis_regs #(
    parameter logic [4:0]  PHY_ADDR           = `PCIS_PHY_ADDR_DEF,
    parameter int unsigned ENERGY_TIMEOUT_CYC = `PCIS_ENERGY_MS * `PCIS_CLK_KHZ
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // Management interface pins
    input  wire logic             mdc,
    input  wire logic             mdio_in,
    output logic                  mdio_out,
    output logic                  mdio_oe,
    // Strap pin
    input  wire logic             crossover_strap_pin,
    // PHY core status and controls
    input  pcis_pkg::pcis_line_t  line_status,
    output pcis_pkg::pcis_xover_t xover,
    output logic                  energy_present,
    output logic                  phy_irq
);

    // Parameter check
    if (ENERGY_TIMEOUT_CYC < 1)
    begin : g_bad_timeout
        $error("ENERGY_TIMEOUT_CYC must be at least one");
    end

    pcis_pkg::pcis_state_t st;
    pcis_pkg::pcis_state_t next_st;
    logic [2:0]            pins_s;
    logic                  mdc_s;
    logic                  mdio_s;
    logic                  strap_s;
    logic                  mdc_rise;
    logic [15:0]           rdata;
    logic [7:1]            ev;
    logic [7:1]            clr;
    logic [4:0]            hdr_idx;
    logic                  hdr_mapped;

    // Pins enter the clock domain through two flops
    pcis_sync #(
        .WIDTH (3)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in ({mdc, mdio_in, crossover_strap_pin}),
        .sync_out (pins_s)
    );

    assign mdc_s    = pins_s[2];
    assign mdio_s   = pins_s[1];
    assign strap_s  = pins_s[0];
    assign mdc_rise = mdc_s & ~st.mdc_prev;

    // Index of the frame in flight, complete at its last header bit
    assign hdr_idx = {st.shift[3:0], mdio_s};

    // Only the four bank indexes are answered; others leave the line released
    always_comb
    begin
        unique case (hdr_idx)
            `PCIS_IDX_XOVER,
            `PCIS_IDX_IRQ_FLAGS,
            `PCIS_IDX_IRQ_MASK,
            `PCIS_IDX_NEG_STATUS:
                hdr_mapped = 1'b1;
            default:
                hdr_mapped = 1'b0;
        endcase
    end

    // Read value of the addressed register
    always_comb
    begin
        rdata = 16'h0000;
        unique case (st.idx)
            `PCIS_IDX_XOVER:
            begin
                rdata[`PCIS_XO_OVERRIDE_BIT] = st.xo_override;
                rdata[`PCIS_XO_AUTO_BIT]     = st.xo_auto;
                rdata[`PCIS_XO_MANUAL_BIT]   = st.xo_manual;
                rdata[`PCIS_XO_PLL_BIT]      = st.pll_ref;
                rdata[`PCIS_XO_POL_BIT]      = line_status.rx_polarity_reversed;
            end
            `PCIS_IDX_IRQ_FLAGS:
                rdata[7:1] = st.flags;
            `PCIS_IDX_IRQ_MASK:
                rdata[7:0] = st.mask;
            `PCIS_IDX_NEG_STATUS:
            begin
                rdata[`PCIS_NS_DONE_BIT] = line_status.an_done;
                rdata[`PCIS_NS_RSV_HI:`PCIS_NS_RSV_LO] = st.ns_rsv;
                rdata[`PCIS_NS_SPD_HI:`PCIS_NS_SPD_LO] =
                    line_status.resolved_speed_duplex;
            end
            default:
                rdata = 16'h0000;
        endcase
    end

    // Next state of the whole bank
    always_comb
    begin
        next_st          = st;
        next_st.mdc_prev = mdc_s;
        clr              = 7'h00;

        // Energy timer restarts on every sign of line energy
        if (line_status.line_energy)
        begin
            next_st.energy_cnt     = 32'h0000_0000;
            next_st.energy_present = 1'b1;
        end
        else if (st.energy_cnt >= ENERGY_TIMEOUT_CYC - 32'h0000_0001)
        begin
            next_st.energy_present = 1'b0;
        end
        else
        begin
            next_st.energy_cnt = st.energy_cnt + 32'h0000_0001;
        end
        // Negotiation done is edge detected; a held level raises one flag
        next_st.an_prev = line_status.an_done;

        // Interrupt causes of this cycle
        ev                        = 7'h00;
        ev[`PCIS_IRQ_ENERGY]      = next_st.energy_present ^ st.energy_present;
        ev[`PCIS_IRQ_NEG_DONE]    = line_status.an_done & ~st.an_prev;
        ev[`PCIS_IRQ_REM_FAULT]   = line_status.remote_fault;
        ev[`PCIS_IRQ_LINK_DOWN]   = ~line_status.link_up;
        ev[`PCIS_IRQ_PARTNER_ACK] = line_status.partner_ack;
        ev[`PCIS_IRQ_PAR_FAULT]   = line_status.parallel_fault;
        ev[`PCIS_IRQ_PAGE_RX]     = line_status.page_rx;

        // Frame engine, one step per rising management clock edge
        if (mdc_rise)
        begin
            unique case (st.phase)
                pcis_pkg::PCIS_PREAMBLE:
                begin
                    // A one then a zero marks the start of a frame
                    if (mdio_s)
                        next_st.pre_seen = 1'b1;
                    else if (st.pre_seen)
                        next_st.phase = pcis_pkg::PCIS_START;
                end
                pcis_pkg::PCIS_START:
                begin
                    next_st.pre_seen = 1'b0;
                    next_st.cnt      = 5'h00;
                    next_st.phase    = mdio_s ? pcis_pkg::PCIS_HEADER
                                              : pcis_pkg::PCIS_PREAMBLE;
                end
                pcis_pkg::PCIS_HEADER:
                begin
                    next_st.shift = {st.shift[14:0], mdio_s};
                    next_st.cnt   = st.cnt + 5'h01;
                    if (next_st.cnt == `PCIS_HDR_BITS)
                    begin
                        next_st.idx     = next_st.shift[4:0];
                        next_st.is_read = next_st.shift[11:10] == `PCIS_OP_READ;
                        // Wrong address, op code or index: the frame runs on unanswered
                        next_st.hit     = next_st.shift[9:5] == PHY_ADDR &&
                                          hdr_mapped &&
                                          (next_st.shift[11:10] == `PCIS_OP_READ ||
                                           next_st.shift[11:10] == `PCIS_OP_WRITE);
                        next_st.cnt     = 5'h00;
                        next_st.phase   = pcis_pkg::PCIS_TURN;
                    end
                end
                pcis_pkg::PCIS_TURN:
                begin
                    next_st.cnt = st.cnt + 5'h01;
                    if (st.is_read)
                    begin
                        // Drive zero in the second turnaround bit
                        next_st.cnt      = 5'h00;
                        next_st.shift    = rdata;
                        next_st.mdio_out = 1'b0;
                        next_st.mdio_oe  = st.hit;
                        next_st.phase    = pcis_pkg::PCIS_RDATA;
                        if (st.hit && st.idx == `PCIS_IDX_IRQ_FLAGS)
                            clr = st.flags;
                    end
                    // Writes let both turnaround bits pass before data
                    else if (next_st.cnt == `PCIS_TA_BITS)
                    begin
                        next_st.cnt   = 5'h00;
                        next_st.phase = pcis_pkg::PCIS_WDATA;
                    end
                end
                pcis_pkg::PCIS_RDATA:
                begin
                    // Bit 0 has been sampled once the count reaches sixteen
                    if (st.cnt == `PCIS_DATA_BITS)
                    begin
                        next_st.mdio_oe  = 1'b0;
                        next_st.mdio_out = 1'b0;
                        next_st.phase    = pcis_pkg::PCIS_PREAMBLE;
                    end
                    else
                    begin
                        next_st.mdio_out = st.shift[15];
                        next_st.shift    = {st.shift[14:0], 1'b0};
                        next_st.cnt      = st.cnt + 5'h01;
                    end
                end
                pcis_pkg::PCIS_WDATA:
                begin
                    next_st.shift = {st.shift[14:0], mdio_s};
                    next_st.cnt   = st.cnt + 5'h01;
                    if (next_st.cnt == `PCIS_DATA_BITS)
                    begin
                        next_st.phase = pcis_pkg::PCIS_PREAMBLE;
                        if (st.hit)
                        begin
                            unique case (st.idx)
                                `PCIS_IDX_XOVER:
                                begin
                                    // Bits 3:0 and reserved bits are dropped
                                    next_st.xo_override =
                                        next_st.shift[`PCIS_XO_OVERRIDE_BIT];
                                    next_st.xo_auto   = next_st.shift[`PCIS_XO_AUTO_BIT];
                                    next_st.xo_manual = next_st.shift[`PCIS_XO_MANUAL_BIT];
                                    next_st.pll_ref   = next_st.shift[`PCIS_XO_PLL_BIT];
                                end
                                `PCIS_IDX_IRQ_MASK:
                                    next_st.mask = next_st.shift[7:0];
                                `PCIS_IDX_NEG_STATUS:
                                    next_st.ns_rsv =
                                        next_st.shift[`PCIS_NS_RSV_HI:`PCIS_NS_RSV_LO];
                                default:
                                    next_st.mask = st.mask;
                            endcase
                        end
                    end
                end
                default:
                    next_st.phase = pcis_pkg::PCIS_PREAMBLE;
            endcase
        end

        // Event wins over a clear in the same cycle
        next_st.flags = (st.flags & ~clr) | ev;
        next_st.irq   = |(next_st.flags & next_st.mask[7:1]);

        // Crossover selection; strap rules unless overridden
        next_st.xover.auto_en = next_st.xo_override ? next_st.xo_auto
                                                    : strap_s;
        next_st.xover.manual_swap = next_st.xo_override & ~next_st.xo_auto &
                                    next_st.xo_manual;
        next_st.xover.rx_pll_ref_lock = next_st.pll_ref;
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st                 <= '0;
            st.phase           <= pcis_pkg::PCIS_PREAMBLE;
            st.mask            <= `PCIS_MASK_RST;
            st.ns_rsv          <= `PCIS_NS_RSV_RST;
            // Energy counts as present until the quiet timer runs out
            st.energy_present  <= 1'b1;
            st.an_prev         <= line_status.an_done;
            st.flags[`PCIS_IRQ_LINK_DOWN] <= ~line_status.link_up;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign mdio_out       = st.mdio_out;
    assign mdio_oe        = st.mdio_oe;
    assign xover          = st.xover;
    assign energy_present = st.energy_present;
    assign phy_irq        = st.irq;

endmodule

// ===== pcis_regs_properties.sv
`timescale 1ns/1ps
// Port-level checks of the management register bank
module pcis_regs_checker #(
    parameter int unsigned ENERGY_TIMEOUT_CYC = 20
) (
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  srst,
    // Management pins
    input wire logic                  mdc,
    input wire logic                  mdio_out,
    input wire logic                  mdio_oe,
    // Core side
    input wire pcis_pkg::pcis_line_t  line_status,
    input wire pcis_pkg::pcis_xover_t xover,
    input wire logic                  energy_present,
    input wire logic                  phy_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    logic [4:0]  since_rise;
    logic [4:0]  oe_rises;
    logic [31:0] quiet;

    // Cycles since mdc rose, mdc rises while driving, cycles without energy
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            since_rise <= 5'h1F;
            oe_rises   <= 5'h00;
            quiet      <= 32'h0;
        end
        else
        begin
            since_rise <= $rose(mdc) ? 5'h00 : since_rise + 5'(since_rise != 5'h1F);
            oe_rises   <= mdio_oe ? oe_rises + 5'($rose(mdc)) : 5'h00;
            quiet      <= line_status.line_energy ? 32'h0 :
                          quiet + 32'(quiet < ENERGY_TIMEOUT_CYC + 8);
        end
    end

    // Turnaround bit driven low shortly after an mdc rise
    sequence s_ta_bit;
        !mdio_out ##0 (since_rise inside {[5'd1:5'd8]});
    endsequence

    a_reset_idle: assert property ($fell(srst) |-> !mdio_oe && !phy_irq && energy_present
        && !xover.manual_swap && !xover.rx_pll_ref_lock) else $error("reset values wrong");
    a_xover_exclusive: assert property (!(xover.auto_en && xover.manual_swap))
        else $error("auto and manual crossover together");
    a_ctrl_by_write: assert property (($changed(xover.rx_pll_ref_lock)
        || $changed(xover.manual_swap)) |-> since_rise inside {[5'd1:5'd8]})
        else $error("control changed outside a write");
    a_ta_drive: assert property ($rose(mdio_oe) |-> s_ta_bit)
        else $error("turnaround drive wrong");
    a_read_length: assert property ($fell(mdio_oe) |-> (oe_rises == 5'd17) ##1 !mdio_oe [*8])
        else $error("read drive length wrong");
    a_bit_timing: assert property ($changed(mdio_out) && mdio_oe |->
        since_rise inside {[5'd1:5'd8]}) else $error("data bit changed off time");
    a_energy_seen: assert property (line_status.line_energy |-> ##[1:2] energy_present)
        else $error("energy not reported");
    a_energy_hold: assert property ($fell(energy_present) |-> quiet >= ENERGY_TIMEOUT_CYC - 2)
        else $error("energy dropped early");
    a_energy_drop: assert property (quiet == ENERGY_TIMEOUT_CYC + 4 |-> !energy_present)
        else $error("energy not dropped");
endmodule

bind pcis_regs pcis_regs_checker #(.ENERGY_TIMEOUT_CYC(ENERGY_TIMEOUT_CYC)) chk_u (
    .core_clk(core_clk), .srst(srst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .line_status(line_status), .xover(xover), .energy_present(energy_present),
    .phy_irq(phy_irq));

// ===== pcis_smi_model.sv
`timescale 1ns/1ps
// Station manager: drives mdc and the shared data line
module pcis_smi_model #(
    parameter int HALF = 8
) (
    // Clock
    input  wire logic core_clk,
    // Management pins
    output logic      mdc,
    output logic      mdio_in,
    input  wire logic mdio_out,
    input  wire logic mdio_oe
);
    logic m_oe;
    logic m_bit;

    // Shared line, pulled up when nobody drives
    assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_bit : 1'b1);

    initial
    begin
        mdc   = 1'b0;
        m_oe  = 1'b0;
        m_bit = 1'b1;
    end

    // Whole frame: preamble, header, turnaround, 16 data bits MSB first
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rdat);
        logic [63:0] f;
        f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 0; i < 64; i++)
        begin
            mdc   <= 1'b0;
            m_oe  <= (op != 2'h2) || (i < 46); // Line released from turnaround on reads
            m_bit <= f[63-i];
            repeat (HALF) @(posedge core_clk);
            mdc <= 1'b1;
            if (i >= 48)
                rdat[63-i] = mdio_in;
            repeat (HALF) @(posedge core_clk);
        end
        mdc  <= 1'b0;
        m_oe <= 1'b0;
        repeat (HALF) @(posedge core_clk); // Idle gap so frames never meet in one step
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 16'(e), 16'(g))

// Self-checking bench for the management register bank
module tb;
    logic                  core_clk;
    logic                  srst;
    logic                  mdc;
    logic                  mdio_in;
    logic                  mdio_out;
    logic                  mdio_oe;
    logic                  strap;
    pcis_pkg::pcis_line_t  ls;
    pcis_pkg::pcis_xover_t xo;
    logic                  energy_present;
    logic                  phy_irq;
    logic [15:0]           rd_data;
    logic [2:0]            codes [4];
    int                    miscompares;
    int                    comparisons;

    pcis_regs #(.ENERGY_TIMEOUT_CYC(20)) dut_u (.core_clk(core_clk), .srst(srst), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .crossover_strap_pin(strap),
        .line_status(ls), .xover(xo), .energy_present(energy_present), .phy_irq(phy_irq));
    pcis_smi_model smi_u (.core_clk(core_clk), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe));

    always #2.5 core_clk = ~core_clk;

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        smi_u.xfer(2'h1, pa, ra, d, rd_data);
    endtask

    task automatic rd(input string n, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] e);
        smi_u.xfer(2'h2, pa, ra, 16'h0000, rd_data);
        `CHK(n, e, rd_data);
    endtask

    // One interrupt cause k, then back to a quiet line
    task automatic fire(input int k);
        case (k)
            1: ls.page_rx <= 1'b1;
            2: ls.parallel_fault <= 1'b1;
            3: ls.partner_ack <= 1'b1;
            4: ls.link_up <= 1'b0;
            5: ls.remote_fault <= 1'b1;
            6: ls.an_done <= 1'b1;
            default: ls.line_energy <= 1'b0;
        endcase
        repeat (k == 7 ? 40 : 1) @(posedge core_clk);
        if (k == 7)
            `CHK("energy_present", 1'b0, energy_present);
        ls <= {2'b11, ls.an_done, 4'h0, ls[3:0]};
        repeat (6) @(posedge core_clk);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        core_clk    = 1'b0;
        srst        = 1'b1;
        strap       = 1'b0;
        ls          = 11'h20D; // Link down, energy seen, reversed polarity, 10 Mb/s full
        miscompares = 0;
        comparisons = 0;
        codes       = '{3'b001, 3'b101, 3'b010, 3'b110};
        repeat (10) @(posedge core_clk);
        srst       <= 1'b0;
        ls.link_up <= 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK("phy_irq", 1'b0, phy_irq);
        rd("mask", 5'h01, 5'h1E, 16'h0000);
        rd("xover_reg", 5'h01, 5'h1B, 16'h0010);
        rd("flags", 5'h01, 5'h1D, 16'h0010);
        rd("flags", 5'h01, 5'h1D, 16'h0000);
        foreach (codes[i])
        begin
            ls.resolved_speed_duplex <= codes[i];
            @(posedge core_clk);
            rd("status", 5'h01, 5'h1F, {11'h002, codes[i], 2'b00});
        end
        $display("Test reset values done");
        strap <= 1'b1;
        repeat (8) @(posedge core_clk);
        `CHK("xover", 3'b100, xo);
        strap <= 1'b0;
        wr(5'h01, 5'h1B, 16'hA40F);
        rd("xover_reg", 5'h01, 5'h1B, 16'hA410);
        `CHK("xover", 3'b011, xo);
        wr(5'h01, 5'h1B, 16'hC000);
        `CHK("xover", 3'b100, xo);
        wr(5'h01, 5'h1B, 16'h0000);
        `CHK("xover", 3'b000, xo);
        $display("Test crossover done");
        wr(5'h01, 5'h1E, 16'hFFAA);
        rd("mask", 5'h01, 5'h1E, 16'h00AA);
        wr(5'h02, 5'h1E, 16'h0000);
        rd("mask", 5'h01, 5'h1E, 16'h00AA);
        rd("other_addr", 5'h02, 5'h1E, 16'hFFFF);
        rd("unmapped", 5'h01, 5'h00, 16'hFFFF);
        $display("Test addressing done");
        for (int k = 1; k < 8; k++)
        begin
            wr(5'h01, 5'h1E, (k % 2 == 0) ? 16'(1 << k) : 16'(8'hFF ^ (8'h01 << k)));
            fire(k);
            `CHK("phy_irq", k % 2 == 0, phy_irq);
            rd("flags", 5'h01, 5'h1D, 16'(1 << k));
            rd("flags", 5'h01, 5'h1D, 16'h0000);
            `CHK("phy_irq", 1'b0, phy_irq);
        end
        $display("Test interrupt sources done");
        wr(5'h01, 5'h1F, 16'h0040);
        rd("status", 5'h01, 5'h1F, 16'h1058);
        $display("Test status done");
        complete_run();
    end

    // Watchdog against a hung frame
    initial
    begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        complete_run();
    end
endmodule
